// ---- hw/pbc_consts.svh ----
// Offsets, field positions, reset values and frame counts of the control block.
// Included by the control top, the station model and the bench; definitions only.
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

`define PBC_REG_CTRL     5'h00
`define PBC_REG_STAT     5'h01
`define PBC_B_ISOLATE    10
`define PBC_B_RESTART    9
`define PBC_B_DUPLEX     8
`define PBC_B_COLTEST    7
`define PBC_UP_AN_EN     1
`define PBC_RST_ISOLATE  1'b1
`define PBC_RST_RESTART  1'b0
`define PBC_RST_DUPLEX   1'b1
`define PBC_RST_COLTEST  1'b0
`define PBC_RSVD_READ    7'h00
`define PBC_STAT_VALUE   16'h7840
`define PBC_OP_RD        2'h2
`define PBC_OP_WR        2'h1
`define PBC_START_PAT    3'h5
`define PBC_HDR_LAST     5'h0b
`define PBC_BODY_LAST    5'h11
`define PBC_TA_DRIVE     5'h01
`define PBC_PHY_ADDRESS_STRAPS_ZERO   5'h00
`define PBC_STRAP_LOAD   2'h2
`define PBC_STRAP_DONE   2'h3

`endif

// ---- hw/pbc_pkg.sv ----
// Types shared by the control block modules.
// Assumes pbc_consts.svh is on the include path.
package pbc_pkg;

  typedef enum logic [2:0] {
    ST_HUNT,
    ST_HDR,
    ST_RD,
    ST_WR,
    ST_SKIP
  } pbc_mgmt_state_t;

  typedef struct packed {
    logic [3:0] txd;
    logic       tx_en;
    logic       tx_er;
  } pbc_mii_tx_t;

  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       col;
    logic       crs;
  } pbc_mii_rx_t;

endpackage : pbc_pkg

// ---- hw/pbc_sync.sv ----
// Two-stage synchroniser for pins entering the ref_clk domain.
// Assumes each bit is an independent level; no word coherence.
`timescale 1ns/10ps
`default_nettype none

module pbc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage is read only by the second
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : pbc_sync

`default_nettype wire

// ---- hw/pbc_mii_gate.sv ----
// MII side gating: isolate float and collision test loopback.
// Assumes MAC transmit signals are already in the ref_clk domain.
`timescale 1ns/10ps
`default_nettype none

module pbc_mii_gate
  import pbc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        isolate,
  input  wire logic        coltest,
  input  wire pbc_mii_tx_t mac_tx,
  input  wire pbc_mii_rx_t core_rx,
  input  wire logic        tx_clk_src,
  input  wire logic        rx_clk_src,
  output pbc_mii_tx_t      core_tx,
  output pbc_mii_rx_t      mii_rx_o,
  output logic             mii_rx_oe,
  output logic             mii_tx_clk,
  output logic             mii_tx_clk_oe,
  output logic             mii_rx_clk,
  output logic             mii_rx_clk_oe
);

  pbc_mii_rx_t rx_q;
  pbc_mii_rx_t rx_d;
  pbc_mii_tx_t tx_q;
  pbc_mii_tx_t tx_d;

  always_comb begin
    rx_d = core_rx;
    // Test mode: collision mirrors transmit enable
    if (coltest) begin
      rx_d.col = mac_tx.tx_en;
    end
    tx_d = mac_tx;
    // Isolated: transmit inputs ignored, outputs parked low
    if (isolate) begin
      rx_d = '0;
      tx_d = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_q <= '0;
      tx_q <= '0;
    end else begin
      rx_q <= rx_d;
      tx_q <= tx_d;
    end
  end

  assign core_tx       = tx_q;
  assign mii_rx_o      = rx_q;
  assign mii_rx_oe     = !isolate;
  // Clocks pass through ungated; only the enable floats them
  assign mii_tx_clk    = tx_clk_src;
  assign mii_rx_clk    = rx_clk_src;
  assign mii_tx_clk_oe = !isolate;
  assign mii_rx_clk_oe = !isolate;

endmodule : pbc_mii_gate

`default_nettype wire

// ---- hw/pbc_ctrl_top.sv ----
// Basic mode control low field group with serial management slave.
// Assumes the upper field group and negotiation engine share ref_clk;
// management clock, data and straps arrive asynchronously on pins.
`timescale 1ns/10ps
`default_nettype none
`include "pbc_consts.svh"

module pbc_ctrl_top
  import pbc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  input  wire logic [4:0]  phy_address_straps,
  input  wire logic [4:0]  upper_ctrl,
  output logic             ctrl_wr_pulse,
  output logic [15:0]      ctrl_wr_data,
  input  wire logic        an_started,
  input  wire logic        an_duplex_full,
  output logic             an_restart_req,
  output logic             duplex_full_eff,
  output logic             coltest_en,
  output logic             isolate_en,
  input  wire logic        clk25_enable,
  input  wire logic        ref_clock_out_25_src,
  output logic             ref_clock_out_25,
  output logic             ref_clock_out_25_oe,
  input  wire pbc_mii_tx_t mac_tx,
  output pbc_mii_tx_t      core_tx,
  input  wire pbc_mii_rx_t core_rx,
  output pbc_mii_rx_t      mii_rx_o,
  output logic             mii_rx_oe,
  input  wire logic        tx_clk_src,
  input  wire logic        rx_clk_src,
  output logic             mii_tx_clk,
  output logic             mii_tx_clk_oe,
  output logic             mii_rx_clk,
  output logic             mii_rx_clk_oe,
  output logic             line_tx_10m_idle,
  output logic             tx_100m_unshielded_pair_oe,
  output logic             tx_100m_shielded_pair_oe,
  input  wire logic        rx_100m_pair_act,
  input  wire logic        line_rx_10m_act,
  output logic             core_rx_100m_act,
  output logic             core_rx_10m_act,
  output logic             link_enable
);

  logic [3:0]      pins_s;
  logic [4:0]      straps_s;
  logic            mdc_s;
  logic            din;
  logic            rise;
  logic            fall;
  logic            an_en;
  logic            wr_ctrl;
  logic [15:0]     wdata;
  logic [15:0]     ctrl_rd;
  logic [11:0]     hdr;

  pbc_mgmt_state_t state_q;
  pbc_mgmt_state_t state_d;
  logic [4:0]      bit_cnt_q;
  logic [4:0]      bit_cnt_d;
  logic [17:0]     sr_q;
  logic [17:0]     sr_d;
  logic [2:0]      hunt_q;
  logic [2:0]      hunt_d;
  logic [15:0]     rd_q;
  logic [15:0]     rd_d;
  logic [4:0]      ra_q;
  logic [4:0]      ra_d;
  logic            mdc_prev_q;
  logic            mdc_prev_d;
  logic            mdio_o_q;
  logic            mdio_o_d;
  logic            mdio_oe_q;
  logic            mdio_oe_d;

  logic [1:0]      str_cnt_q;
  logic [1:0]      str_cnt_d;
  logic [4:0]      addr_q;
  logic [4:0]      addr_d;
  logic            isolate_q;
  logic            isolate_d;
  logic            restart_q;
  logic            restart_d;
  logic            duplex_q;
  logic            duplex_d;
  logic            coltest_q;
  logic            coltest_d;
  logic            wr_pulse_q;
  logic            wr_pulse_d;
  logic [15:0]     wr_data_q;
  logic [15:0]     wr_data_d;
  logic            dup_eff_q;
  logic            dup_eff_d;

  pbc_sync #(.W(4)) u_sync_pins (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in ({mdc, mdio_i, rx_100m_pair_act, line_rx_10m_act}),
    .sync_out (pins_s)
  );

  pbc_sync #(.W(5)) u_sync_straps (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (phy_address_straps),
    .sync_out (straps_s)
  );

  function automatic logic [15:0] pbc_rd_word(input logic [4:0]  ra,
                                               input logic [15:0] ctrl);
    if (ra == `PBC_REG_CTRL) begin
      return ctrl;
    end else if (ra == `PBC_REG_STAT) begin
      return `PBC_STAT_VALUE;
    end
    return 16'h0000;
  endfunction : pbc_rd_word

  assign mdc_s = pins_s[3];
  assign din   = pins_s[2];
  assign rise  = mdc_s && !mdc_prev_q;
  assign fall  = !mdc_s && mdc_prev_q;
  assign an_en = upper_ctrl[`PBC_UP_AN_EN];
  assign hdr   = {sr_q[10:0], din};
  assign wdata = {sr_q[14:0], din};
  // Reserved bits read as zero; writes to them are dropped
  assign ctrl_rd = {upper_ctrl, isolate_q, restart_q, duplex_q, coltest_q, `PBC_RSVD_READ};
  assign wr_ctrl = rise && (state_q == ST_WR) && (bit_cnt_q == `PBC_BODY_LAST) && (ra_q == `PBC_REG_CTRL);

  // Management frame engine; never gated by isolate
  always_comb begin
    state_d    = state_q;
    bit_cnt_d  = bit_cnt_q;
    sr_d       = sr_q;
    hunt_d     = hunt_q;
    rd_d       = rd_q;
    ra_d       = ra_q;
    mdc_prev_d = mdc_s;
    mdio_o_d   = mdio_o_q;
    mdio_oe_d  = mdio_oe_q;
    if (rise) begin
      unique case (state_q)
        ST_HUNT: begin
          // Idle one then start bits; preamble may be suppressed
          hunt_d = {hunt_q[1:0], din};
          if ({hunt_q[1:0], din} == `PBC_START_PAT) begin
            state_d   = ST_HDR;
            bit_cnt_d = 5'h00;
          end
        end
        ST_HDR: begin
          sr_d      = {sr_q[16:0], din};
          bit_cnt_d = bit_cnt_q + 5'h01;
          if (bit_cnt_q == `PBC_HDR_LAST) begin
            bit_cnt_d = 5'h00;
            ra_d      = hdr[4:0];
            state_d   = ST_SKIP;
            if (hdr[9:5] == addr_q && hdr[11:10] == `PBC_OP_RD) begin
              state_d = ST_RD;
              rd_d    = pbc_rd_word(hdr[4:0], ctrl_rd);
            end else if (hdr[9:5] == addr_q && hdr[11:10] == `PBC_OP_WR) begin
              state_d = ST_WR;
            end
          end
        end
        ST_RD, ST_WR, ST_SKIP: begin
          sr_d      = {sr_q[16:0], din};
          bit_cnt_d = bit_cnt_q + 5'h01;
          if (bit_cnt_q == `PBC_BODY_LAST) begin
            state_d = ST_HUNT;
            hunt_d  = 3'h0;
          end
        end
      endcase
    end
    if (fall) begin
      // Slave changes data on falling edges; master samples on rising
      if (state_q == ST_RD && bit_cnt_q >= `PBC_TA_DRIVE) begin
        mdio_oe_d = 1'b1;
        if (bit_cnt_q == `PBC_TA_DRIVE) begin
          mdio_o_d = 1'b0;
        end else begin
          mdio_o_d = rd_q[15];
          rd_d     = {rd_q[14:0], 1'b0};
        end
      end else begin
        mdio_oe_d = 1'b0;
        mdio_o_d  = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= ST_HUNT;
      bit_cnt_q  <= 5'h00;
      sr_q       <= 18'h00000;
      hunt_q     <= 3'h0;
      rd_q       <= 16'h0000;
      ra_q       <= 5'h00;
      mdc_prev_q <= 1'b0;
      mdio_o_q   <= 1'b0;
      mdio_oe_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      bit_cnt_q  <= bit_cnt_d;
      sr_q       <= sr_d;
      hunt_q     <= hunt_d;
      rd_q       <= rd_d;
      ra_q       <= ra_d;
      mdc_prev_q <= mdc_prev_d;
      mdio_o_q   <= mdio_o_d;
      mdio_oe_q  <= mdio_oe_d;
    end
  end

  // Control field group
  always_comb begin
    str_cnt_d  = str_cnt_q;
    addr_d     = addr_q;
    isolate_d  = isolate_q;
    restart_d  = restart_q;
    duplex_d   = duplex_q;
    coltest_d  = coltest_q;
    wr_pulse_d = wr_ctrl;
    wr_data_d  = wr_ctrl ? wdata : wr_data_q;
    // Duplex bit only matters without negotiation
    dup_eff_d  = an_en ? an_duplex_full : duplex_q;
    if (str_cnt_q != `PBC_STRAP_DONE) begin
      str_cnt_d = str_cnt_q + 2'h1;
    end
    // Straps caught once they clear the synchroniser
    if (str_cnt_q == `PBC_STRAP_LOAD) begin
      addr_d    = straps_s;
      isolate_d = (straps_s == `PBC_PHY_ADDRESS_STRAPS_ZERO);
    end
    // Self-clear once the engine reports the start
    if (an_started) begin
      restart_d = 1'b0;
    end
    if (!an_en) begin
      restart_d = 1'b0;
    end
    if (wr_ctrl) begin
      isolate_d = wdata[`PBC_B_ISOLATE];
      duplex_d  = wdata[`PBC_B_DUPLEX];
      coltest_d = wdata[`PBC_B_COLTEST];
      // Written zero never clears a pending start new request wins over the clear
      if (wdata[`PBC_B_RESTART] && an_en) begin
        restart_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      str_cnt_q  <= 2'h0;
      addr_q     <= `PBC_PHY_ADDRESS_STRAPS_ZERO;
      isolate_q  <= `PBC_RST_ISOLATE;
      restart_q  <= `PBC_RST_RESTART;
      duplex_q   <= `PBC_RST_DUPLEX;
      coltest_q  <= `PBC_RST_COLTEST;
      wr_pulse_q <= 1'b0;
      wr_data_q  <= 16'h0000;
      dup_eff_q  <= `PBC_RST_DUPLEX;
    end else begin
      str_cnt_q  <= str_cnt_d;
      addr_q     <= addr_d;
      isolate_q  <= isolate_d;
      restart_q  <= restart_d;
      duplex_q   <= duplex_d;
      coltest_q  <= coltest_d;
      wr_pulse_q <= wr_pulse_d;
      wr_data_q  <= wr_data_d;
      dup_eff_q  <= dup_eff_d;
    end
  end

  pbc_mii_gate u_gate (
    .ref_clk       (ref_clk),
    .rst_b         (rst_b),
    .isolate       (isolate_q),
    .coltest       (coltest_q),
    .mac_tx        (mac_tx),
    .core_rx       (core_rx),
    .tx_clk_src    (tx_clk_src),
    .rx_clk_src    (rx_clk_src),
    .core_tx       (core_tx),
    .mii_rx_o      (mii_rx_o),
    .mii_rx_oe     (mii_rx_oe),
    .mii_tx_clk    (mii_tx_clk),
    .mii_tx_clk_oe (mii_tx_clk_oe),
    .mii_rx_clk    (mii_rx_clk),
    .mii_rx_clk_oe (mii_rx_clk_oe)
  );

  assign mdio_o          = mdio_o_q;
  assign mdio_oe         = mdio_oe_q;
  assign ctrl_wr_pulse   = wr_pulse_q;
  assign ctrl_wr_data    = wr_data_q;
  assign an_restart_req  = restart_q;
  assign duplex_full_eff = dup_eff_q;
  assign coltest_en      = coltest_q;
  assign isolate_en      = isolate_q;
  // Reference clock ignores isolate by design
  assign ref_clock_out_25    = ref_clock_out_25_src;
  assign ref_clock_out_25_oe = clk25_enable;
  // Line side held quiet while isolated
  assign line_tx_10m_idle           = isolate_q;
  assign tx_100m_unshielded_pair_oe = !isolate_q;
  assign tx_100m_shielded_pair_oe   = !isolate_q;
  assign core_rx_100m_act           = pins_s[1] && !isolate_q;
  assign core_rx_10m_act            = pins_s[0] && !isolate_q;
  assign link_enable                = !isolate_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_iso_float;
    // Enables follow the bit at once; registered MII paths clear one cycle later
    isolate_q |-> (!mii_rx_oe && !mii_tx_clk_oe && !mii_rx_clk_oe) ##1 (core_tx == '0 && mii_rx_o == '0);
  endproperty
  a_iso_float: assert property (p_iso_float) else $error("isolate did not float MII");

  property p_iso_mgmt;
    isolate_q && fall && state_q == ST_RD && bit_cnt_q == 5'h02 |=> mdio_oe;
  endproperty
  a_iso_mgmt: assert property (p_iso_mgmt) else $error("management read not driven");

  property p_iso_line;
    isolate_q |-> line_tx_10m_idle && !tx_100m_unshielded_pair_oe && !link_enable && !core_rx_100m_act;
  endproperty
  a_iso_line: assert property (p_iso_line) else $error("line side active while isolated");

  property p_strap;
    str_cnt_q == `PBC_STRAP_LOAD |=> isolate_q == ($past(straps_s) == `PBC_PHY_ADDRESS_STRAPS_ZERO);
  endproperty
  a_strap: assert property (p_strap) else $error("isolate reset value wrong");

  property p_restart_done;
    an_started && !wr_ctrl |=> !an_restart_req;
  endproperty
  a_restart_done: assert property (p_restart_done) else $error("restart bit not self-cleared");

  property p_restart_set;
    wr_ctrl && wdata[`PBC_B_RESTART] && an_en |=> an_restart_req [*1] ##0 $rose(ctrl_wr_pulse);
  endproperty
  a_restart_set: assert property (p_restart_set) else $error("restart write lost");

  property p_restart_noan;
    !an_en |=> !an_restart_req;
  endproperty
  a_restart_noan: assert property (p_restart_noan) else $error("restart active without enable");

  property p_restart_w0;
    restart_q && wr_ctrl && !wdata[`PBC_B_RESTART] && an_en && !an_started |=> restart_q;
  endproperty
  a_restart_w0: assert property (p_restart_w0) else $error("zero write cleared restart");

  property p_duplex;
    !an_en |=> duplex_full_eff == $past(duplex_q);
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex bit not applied");

  property p_duplex_an;
    an_en && !wr_ctrl |=> duplex_full_eff == $past(an_duplex_full) && $stable(duplex_q);
  endproperty
  a_duplex_an: assert property (p_duplex_an) else $error("duplex bit tracked status");

  property p_col_on;
    coltest_q && !isolate_q && mac_tx.tx_en |=> mii_rx_o.col;
  endproperty
  a_col_on: assert property (p_col_on) else $error("collision test missed");

  property p_col_off;
    coltest_q && !mac_tx.tx_en |=> !mii_rx_o.col;
  endproperty
  a_col_off: assert property (p_col_off) else $error("collision held after enable");

  property p_rsvd;
    rise && state_q == ST_HDR && bit_cnt_q == `PBC_HDR_LAST && hdr[4:0] == `PBC_REG_CTRL
      && hdr[9:5] == addr_q && hdr[11:10] == `PBC_OP_RD |=> rd_q[6:0] == `PBC_RSVD_READ;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  c_write: cover property (wr_ctrl ##1 ctrl_wr_pulse);
  c_iso_read: cover property (isolate_q && state_q == ST_RD && mdio_oe);
  c_restart: cover property (an_restart_req ##[1:1000] an_started);
  c_col: cover property (coltest_q && mii_rx_o.col);

endmodule : pbc_ctrl_top

`default_nettype wire

// ---- verification/pbc_station.sv ----
// Management station model: serial frames on mdc and mdio, MSB first.
// Assumes the bench resolves mdio with a pull-up, device drive first.
`timescale 1ns/10ps
`default_nettype none
`include "pbc_consts.svh"

module pbc_station #(
  parameter int HALF = 8
) (
  input  wire logic ref_clk,
  input  wire logic mdio,
  output logic      mdc,
  output logic      drv,
  output logic      drv_oe
);
  initial begin
    mdc    = 1'b0;
    drv    = 1'b1;
    drv_oe = 1'b0;
  end

  // Slow mdc so the device's two-flop sync sees every edge
  task automatic bit_io(input logic oe, input logic b, output logic s);
    mdc    = 1'b0;
    drv    = oe ? b : !b;
    drv_oe = oe;
    repeat (HALF) @(negedge ref_clk);
    mdc = 1'b1;
    s   = mdio;
    repeat (HALF) @(negedge ref_clk);
  endtask : bit_io

  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] fr;
    logic        wr;
    logic        s;
    wr      = (op == `PBC_OP_WR);
    wd[6:0] = 7'h00; // Reserved bits always sent as zero
    fr      = {2'b01, op, phy, rg, 2'b10, wd};
    rd      = 16'h0000;
    bit_io(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      bit_io(wr || i > 17, fr[i], s);
      if (i < 16) rd[i] = s;
    end
    // Released idle bit lets the device drop its drive
    bit_io(1'b0, 1'b1, s);
    // Park mdc low so a reset never meets a high clock and a false edge
    mdc = 1'b0;
  endtask : xfer
endmodule : pbc_station
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the control low field group.
// Assumes pbc_consts.svh on the include path; station model drives mdio.
`timescale 1ns/10ps
`default_nettype none
`include "pbc_consts.svh"
`define CHK(n, e, g) check(n, 16'(e), 16'(g))

module tb;
  import pbc_pkg::*;
  logic        ref_clk, rst_b, mdc, mdio_o, mdio_oe, sta_bit, sta_oe, mdio_w;
  logic        ctrl_wr_pulse, an_started, an_duplex_full, an_restart_req, duplex_full_eff;
  logic        coltest_en, isolate_en, clk25_enable, ref_clock_out_25_src, ref_clock_out_25;
  logic        ref_clock_out_25_oe, mii_rx_oe, tx_clk_src, rx_clk_src, mii_tx_clk, mii_tx_clk_oe;
  logic        mii_rx_clk, mii_rx_clk_oe, line_tx_10m_idle, tx_100m_unshielded_pair_oe;
  logic        tx_100m_shielded_pair_oe, rx_100m_pair_act, line_rx_10m_act;
  logic        core_rx_100m_act, core_rx_10m_act, link_enable;
  logic [4:0]  phy_address_straps, upper_ctrl, phy;
  logic [15:0] ctrl_wr_data;
  pbc_mii_tx_t mac_tx, core_tx;
  pbc_mii_rx_t core_rx, mii_rx_o;
  int          mismatches, num_checks, cycles, wr_pulses;

  // Pull-up on the shared management line
  assign mdio_w = mdio_oe ? mdio_o : (sta_oe ? sta_bit : 1'b1);

  pbc_ctrl_top i_dut (
    .ref_clk, .rst_b, .mdc, .mdio_i(mdio_w), .mdio_o, .mdio_oe, .phy_address_straps, .upper_ctrl,
    .ctrl_wr_pulse, .ctrl_wr_data, .an_started, .an_duplex_full, .an_restart_req, .duplex_full_eff,
    .coltest_en, .isolate_en, .clk25_enable, .ref_clock_out_25_src, .ref_clock_out_25,
    .ref_clock_out_25_oe, .mac_tx, .core_tx, .core_rx, .mii_rx_o, .mii_rx_oe, .tx_clk_src, .rx_clk_src,
    .mii_tx_clk, .mii_tx_clk_oe, .mii_rx_clk, .mii_rx_clk_oe, .line_tx_10m_idle,
    .tx_100m_unshielded_pair_oe, .tx_100m_shielded_pair_oe, .rx_100m_pair_act, .line_rx_10m_act,
    .core_rx_100m_act, .core_rx_10m_act, .link_enable
  );

  pbc_station i_sta (.ref_clk, .mdio(mdio_w), .mdc, .drv(sta_bit), .drv_oe(sta_oe));

  always #5 ref_clk = ~ref_clk;

  // Frames take about 550 cycles each; ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (ctrl_wr_pulse === 1'b1) begin
      wr_pulses <= wr_pulses + 1;
    end
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : check

  function automatic logic [15:0] cx(input logic iso, input logic rs, input logic dp, input logic ct);
    return {upper_ctrl, iso, rs, dp, ct, `PBC_RSVD_READ};
  endfunction : cx

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [15:0] d);
    logic [15:0] x;
    i_sta.xfer(`PBC_OP_WR, phy, `PBC_REG_CTRL, d, x);
  endtask : wr

  task automatic rdc(input string n, input logic [4:0] rg, input logic [15:0] e);
    logic [15:0] x;
    i_sta.xfer(`PBC_OP_RD, phy, rg, 16'h0000, x);
    `CHK(n, e, x);
  endtask : rdc

  task automatic do_reset(input logic [4:0] s);
    rst_b              = 1'b0;
    phy_address_straps = s;
    phy                = s;
    cyc(5);
    `CHK("isolate_rst", 1'b1, isolate_en);
    rst_b = 1'b1;
    cyc(6);
  endtask : do_reset

  task automatic clk_pass(input logic iso);
    for (int v = 0; v < 2; v++) begin
      {tx_clk_src, rx_clk_src, ref_clock_out_25_src} = {3{v[0]}};
      cyc(1);
      `CHK("clk25", v[0], ref_clock_out_25);
      `CHK("clk_oe", {2{!iso}}, {mii_tx_clk_oe, mii_rx_clk_oe});
      if (!iso) `CHK("mii_clk", {2{v[0]}}, {mii_tx_clk, mii_rx_clk});
    end
  endtask : clk_pass

  initial begin
    ref_clk    = 1'b0;
    mismatches = 0;
    num_checks = 0;
    cycles     = 0;
    wr_pulses  = 0;
    upper_ctrl = 5'h00;
    {an_started, an_duplex_full, clk25_enable} = 3'b001;
    {tx_clk_src, rx_clk_src, ref_clock_out_25_src} = 3'b000;
    {rx_100m_pair_act, line_rx_10m_act} = 2'b11;
    mac_tx  = '1;
    core_rx = '1;
    do_reset(5'h00);
    `CHK("core_tx_iso", 6'h00, core_tx);
    `CHK("rx_oe_iso", 1'b0, mii_rx_oe);
    `CHK("line_iso", 4'h8, {line_tx_10m_idle, tx_100m_unshielded_pair_oe, tx_100m_shielded_pair_oe, link_enable});
    `CHK("rx_act_iso", 2'b00, {core_rx_100m_act, core_rx_10m_act});
    `CHK("clk25_oe", 1'b1, ref_clock_out_25_oe);
    clk_pass(1'b1);
    clk25_enable = 1'b0;
    cyc(1);
    `CHK("clk25_off", 1'b0, ref_clock_out_25_oe);
    clk25_enable = 1'b1;
    rdc("ctrl_rst", `PBC_REG_CTRL, cx(1'b1, 1'b0, 1'b1, 1'b0));
    rdc("status", `PBC_REG_STAT, `PBC_STAT_VALUE);
    rdc("unmapped", 5'h02, 16'h0000);
    wr(16'h0080);
    `CHK("wr_data", 16'h0080, ctrl_wr_data);
    `CHK("coltest_en", 1'b1, coltest_en);
    `CHK("line_on", 4'h7, {line_tx_10m_idle, tx_100m_unshielded_pair_oe, tx_100m_shielded_pair_oe, link_enable});
    `CHK("rx_act", 2'b11, {core_rx_100m_act, core_rx_10m_act});
    `CHK("rx_oe", 1'b1, mii_rx_oe);
    clk_pass(1'b0);
    rdc("ctrl_ct", `PBC_REG_CTRL, cx(1'b0, 1'b0, 1'b0, 1'b1));
    mac_tx  = 6'h16;
    core_rx = 8'ha4;
    cyc(2);
    `CHK("core_tx", 6'h16, core_tx);
    `CHK("col_test", 8'ha6, mii_rx_o);
    mac_tx = 6'h14;
    cyc(2);
    `CHK("col_drop", 8'ha4, mii_rx_o);
    wr(16'h0000);
    mac_tx = 6'h16;
    cyc(2);
    `CHK("col_off", 8'ha4, mii_rx_o);
    `CHK("coltest_off", 1'b0, coltest_en);
    an_duplex_full = 1'b1;
    cyc(2);
    `CHK("dup_manual", 1'b0, duplex_full_eff);
    upper_ctrl = 5'h02;
    cyc(2);
    `CHK("dup_an", 1'b1, duplex_full_eff);
    rdc("ctrl_dup", `PBC_REG_CTRL, cx(1'b0, 1'b0, 1'b0, 1'b0));
    an_duplex_full = 1'b0;
    cyc(2);
    `CHK("dup_an_half", 1'b0, duplex_full_eff);
    upper_ctrl = 5'h00;
    wr(16'h0100);
    `CHK("dup_full", 1'b1, duplex_full_eff);
    wr(16'h0200);
    `CHK("restart_off", 1'b0, an_restart_req);
    upper_ctrl = 5'h02;
    wr(16'h0200);
    `CHK("restart_req", 1'b1, an_restart_req);
    rdc("ctrl_rs", `PBC_REG_CTRL, cx(1'b0, 1'b1, 1'b0, 1'b0));
    wr(16'h0000);
    `CHK("restart_hold", 1'b1, an_restart_req);
    an_started = 1'b1;
    cyc(1);
    an_started = 1'b0;
    cyc(2);
    `CHK("restart_clr", 1'b0, an_restart_req);
    rdc("ctrl_sc", `PBC_REG_CTRL, cx(1'b0, 1'b0, 1'b0, 1'b0));
    do_reset(5'h03);
    `CHK("isolate_nz", 1'b0, isolate_en);
    rdc("ctrl_nz", `PBC_REG_CTRL, cx(1'b0, 1'b0, 1'b1, 1'b0));
    `CHK("wr_pulses", 6, wr_pulses);
    results();
  end
endmodule : tb
`default_nettype wire
